// ### rtl/sync_serial_frame_engine.v
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "sync_serial_defs.vh"
// Behaviour
// [R1] rx bit clock from transmit clock, divided clock or synced rx clock pin
// [R2] rx sampling inversion never alters the clock driven on the rx pin
// [R3] software must not pick pin source with continuous pin output
// [R4] each frame begins on its start event, optional sync data first
// [R5] holding to shift transfer sets tx ready
// [R6] tx empty while holding and shift register are both empty
// [R7] complete rx word goes to holding register and sets rx ready
// [R8] word completing before holding read sets overrun and overwrites
// [R9] continuous: tx starts on holding write, rx starts once enabled
// [R10] per-side start: other side, edges, levels, changes on frame sync
// [R11] frame sync used internally only as driven on its output pin
// [R12] frame sync waveform: levels in data, pulse 1..16 bits, toggle
// [R13] frame sync pulses repeat per period field, frame up to 512 bits
// [R14] sync data sampled or shifted while frame sync active, length set
// [R15] rx sync data gathered through rx shift register into sync holding
// [R16] tx sync only with enable; data phase takes priority over sync
// [R17] selected frame sync edge sets tx or rx sync flag
// [R18] word up to 32 bits, up to 16 words per frame, msb/lsb first
// [R19] start delay up to 255 bit periods before first data bit
// [R20] tx data line idles at programmed default level
// [R21] continuous tx start never sends sync data
// [R22] loop mode feeds rx from tx data, frame sync and clock
// [R23] enable/disable writes set/clear mask; irq when masked flag pending
// [R24] divided clock: master over twice divider, zero stops it
// [R25] external bit clock at most half master, levels two cycles
// [R26] clock select codes: 0 divided, 1 tx clock, 2 pin, 3 reserved
// [R27] start codes 0 continuous, 1 other side, 2..7 frame sync events
// [R28] external clock and frame sync pass two flip-flops before use
module sync_serial_frame_engine (
   input wire clk,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire rxClockPinIn,
   output reg rxClockPinOut,
   output reg rxClockPinOe,
   input wire rxFrameSyncPinIn,
   output reg rxFrameSyncPinOut,
   output reg rxFrameSyncPinOe,
   input wire rxDataIn,
   output reg txClockPinOut,
   output reg txClockPinOe,
   input wire txFrameSyncPinIn,
   output reg txFrameSyncPinOut,
   output reg txFrameSyncPinOe,
   output reg txDataLine,
   output reg irq
);
   wire [3:0] pinRaw;
   wire [3:0] pinLevel;
   reg [11:0] cmr_q;
   reg [31:0] rcmr_q, rfmr_q, tcmr_q, tfmr_q;
   reg [31:0] txHold_q, rxHold_q, rxSyncHold_q;
   reg [15:0] txSyncHold_q;
   reg txHoldFull_q, rxEn_q, txEn_q;
   reg tx_ready_flag_q, tx_empty_flag_q, rx_ready_flag_q, ovr_q, tx_sync_flag_q, rx_sync_flag_q;
   reg [11:0] imr_q;
   reg wrPend_q;
   reg [7:0] wrAddr_q;
   reg [11:0] divCnt_q;
   reg divClk_q, divPrev_q, rxClkPrev_q;
   reg txRun_q, rxRun_q;
   reg [7:0] txDly_q, rxDly_q;
   reg [4:0] txSync_q, rxSync_q, txBit_q, rxBit_q, txPulse_q, rxPulse_q;
   reg [3:0] txWord_q, rxWord_q;
   reg [8:0] txPer_q, rxPer_q;
   reg [31:0] txShift_q, rxShift_q;
   reg [15:0] txSyncSh_q;
   reg txFsPrev_q, rxFsPrev_q;
   reg [31:0] rdMux;

   // input pins through synchronisers
   assign pinRaw = {rxDataIn, txFrameSyncPinIn, rxFrameSyncPinIn, rxClockPinIn};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         pin_sync u_sync (
            .clk(clk),
            .rst(rst),
            .pinIn(pinRaw[gi]),
            .level(pinLevel[gi]),
            .rise(),
            .fall()
         );
      end
   endgenerate

   // start event decode, shared by both directions
   function startHit;
      input [3:0] mode;
      input lvl;
      input prev;
      input other;
      begin
         case (mode)
            `ST_CONT: startHit = 1'b1;
            `ST_OTHER: startHit = other;
            `ST_LOW: startHit = ~lvl;
            `ST_HIGH: startHit = lvl;
            `ST_FALL: startHit = prev & ~lvl;
            `ST_RISE: startHit = ~prev & lvl;
            `ST_CHANGE: startHit = prev ^ lvl;
            `ST_EDGE: startHit = prev ^ lvl;
            default: startHit = 1'b0;
         endcase
      end
   endfunction

   // frame sync output waveform, shared by both directions
   function fsWave;
      input [2:0] sel;
      input pulse;
      input run;
      input cur;
      input trig;
      begin
         case (sel)
            `FS_NEGPULSE: fsWave = ~pulse;
            `FS_POSPULSE: fsWave = pulse;
            `FS_LOWDATA: fsWave = ~run;
            `FS_HIGHDATA: fsWave = run;
            `FS_TOGGLE: fsWave = cur ^ trig;
            default: fsWave = 1'b0;
         endcase
      end
   endfunction

   // bus decode
   wire addrPhase = hsel & htrans[1] & hready;
   wire rdNow = addrPhase & ~hwrite;
   wire rdRhr = rdNow && haddr[7:0] == `OFS_RHR;
   wire rdSr = rdNow && haddr[7:0] == `OFS_SR;
   wire wrCr = wrPend_q && wrAddr_q == `OFS_CR;
   wire swrst = wrCr & hwdata[`CR_SWRST];
   wire wrThr = wrPend_q && wrAddr_q == `OFS_THR;

   // configuration fields
   wire rxLoop = rfmr_q[`DEFLOOP_BIT];
   wire [3:0] txMode = tcmr_q[`START_RANGE];
   wire [3:0] rxMode = rcmr_q[`START_RANGE];
   wire [4:0] txLen = tfmr_q[`WORD_LENGTH_RANGE];
   wire [4:0] rxLen = rfmr_q[`WORD_LENGTH_RANGE];
   wire [2:0] txFsos = tfmr_q[`FRAME_SYNC_OUTPUT_SELECT_RANGE];
   wire [2:0] rxFsos = rfmr_q[`FRAME_SYNC_OUTPUT_SELECT_RANGE];
   wire [8:0] txPerEnd = {tcmr_q[`PER_RANGE], 1'b1};
   wire [8:0] rxPerEnd = {rcmr_q[`PER_RANGE], 1'b1};

   // receive clock selection and sampling edge
   reg rxClkSel;
   always @* begin
      if (rxLoop)
         rxClkSel = divClk_q; // R22
      else if (rcmr_q[`CKS_RANGE] == `CKS_DIV || rcmr_q[`CKS_RANGE] == `CKS_TXCLK)
         rxClkSel = divClk_q; // R1 R26
      else if (rcmr_q[`CKS_RANGE] == `CKS_PIN)
         rxClkSel = pinLevel[0]; // R1 R28
      else
         rxClkSel = 1'b0;
   end
   wire txTick = divClk_q & ~divPrev_q;
   wire rxTick = rcmr_q[`CKI_BIT] ? (rxClkSel & ~rxClkPrev_q) : (~rxClkSel & rxClkPrev_q); // R2

   // frame sync levels seen internally
   wire txFsLevel = (txFsos != `FS_INPUT) ? txFrameSyncPinOut : pinLevel[2]; // R11
   wire rxFsOwn = (rxFsos != `FS_INPUT) ? rxFrameSyncPinOut : pinLevel[1]; // R11
   wire rxFsLevel = rxLoop ? txFsLevel : rxFsOwn; // R22
   wire rxData = rxLoop ? txDataLine : pinLevel[3]; // R22

   // start events
   wire txGo = (txMode == `ST_CONT) ? txHoldFull_q :
      startHit(txMode, txFsLevel, txFsPrev_q, rxRun_q); // R9 R10 R27
   wire rxGo = startHit(rxMode, rxFsLevel, rxFsPrev_q, txRun_q); // R9 R10 R27
   wire txStart = txTick & txEn_q & ~txRun_q & txGo; // R4
   wire rxStart = rxTick & rxEn_q & ~rxRun_q & rxGo; // R4
   wire txPerWrap = txTick && tcmr_q[`PER_RANGE] != 8'h00 && txPer_q == txPerEnd;
   wire rxPerWrap = rxTick && rcmr_q[`PER_RANGE] != 8'h00 && rxPer_q == rxPerEnd;
   wire txTrig = (tcmr_q[`PER_RANGE] != 8'h00) ? txPerWrap : txStart; // R13
   wire rxTrig = (rcmr_q[`PER_RANGE] != 8'h00) ? rxPerWrap : rxStart; // R13
   wire txWordLoad = txTick & txRun_q & (txDly_q == 8'h00) & (txBit_q == 5'h00);
   wire txXfer = txWordLoad & txHoldFull_q;
   wire rxDataTick = rxTick & rxRun_q & (rxDly_q == 8'h00);
   wire rxDone = rxDataTick & (rxBit_q == rxLen);
   wire [31:0] rxMsbWord = {rxShift_q[30:0], rxData} & (32'hFFFFFFFF >> (5'h1F - rxLen));
   wire [31:0] rxLsbWord = {rxData, rxShift_q[31:1]} >> (5'h1F - rxLen);
   wire txSynEv = txTick && (txFsLevel ^ txFsPrev_q) && (txFsLevel ^ tfmr_q[`FRAME_SYNC_EDGE_SELECT_BIT]);
   wire rxSynEv = rxTick && (rxFsLevel ^ rxFsPrev_q) && (rxFsLevel ^ rfmr_q[`FRAME_SYNC_EDGE_SELECT_BIT]);
   wire [11:0] srFlags = {rx_sync_flag_q, tx_sync_flag_q, 4'h0, ovr_q, rx_ready_flag_q, 2'h0, tx_empty_flag_q, tx_ready_flag_q};

   // bus slave: capture, writes, flags
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
         cmr_q <= 12'h000;
         rcmr_q <= 32'h0;
         rfmr_q <= 32'h0;
         tcmr_q <= 32'h0;
         tfmr_q <= 32'h0;
         txHold_q <= 32'h0;
         txSyncHold_q <= 16'h0000;
         txHoldFull_q <= 1'b0;
         rxEn_q <= 1'b0;
         txEn_q <= 1'b0;
         imr_q <= 12'h000;
         tx_ready_flag_q <= 1'b1;
         rx_ready_flag_q <= 1'b0;
         ovr_q <= 1'b0;
         tx_sync_flag_q <= 1'b0;
         rx_sync_flag_q <= 1'b0;
      end else begin
         wrPend_q <= addrPhase & hwrite;
         wrAddr_q <= haddr[7:0];
         // read side effects first, events afterwards so sets win
         if (rdRhr)
            rx_ready_flag_q <= 1'b0;
         if (rdSr) begin
            ovr_q <= 1'b0;
            tx_sync_flag_q <= 1'b0;
            rx_sync_flag_q <= 1'b0;
         end
         if (txXfer) begin
            txHoldFull_q <= 1'b0;
            tx_ready_flag_q <= 1'b1; // R5
         end
         if (rxDone) begin
            rx_ready_flag_q <= 1'b1; // R7
            if (rx_ready_flag_q && !rdRhr)
               ovr_q <= 1'b1; // R8
         end
         if (txSynEv)
            tx_sync_flag_q <= 1'b1; // R17
         if (rxSynEv)
            rx_sync_flag_q <= 1'b1; // R17
         if (wrCr) begin
            if (hwdata[`CR_RXEN])
               rxEn_q <= 1'b1;
            if (hwdata[`CR_RXDIS])
               rxEn_q <= 1'b0;
            if (hwdata[`CR_TXEN])
               txEn_q <= 1'b1;
            if (hwdata[`CR_TXDIS])
               txEn_q <= 1'b0;
         end
         if (wrPend_q) begin
            if (wrAddr_q == `OFS_CMR)
               cmr_q <= hwdata[`DIV_RANGE];
            else if (wrAddr_q == `OFS_RCMR)
               rcmr_q <= hwdata & `CLKMODE_MASK;
            else if (wrAddr_q == `OFS_RFMR)
               rfmr_q <= hwdata & `FRMMODE_MASK;
            else if (wrAddr_q == `OFS_TCMR)
               tcmr_q <= hwdata & `CLKMODE_MASK;
            else if (wrAddr_q == `OFS_TFMR)
               tfmr_q <= hwdata & `FRMMODE_MASK;
            else if (wrAddr_q == `OFS_TSHR)
               txSyncHold_q <= hwdata[15:0];
            else if (wrAddr_q == `OFS_IER)
               imr_q <= imr_q | (hwdata[11:0] & `IMR_MASK); // R23
            else if (wrAddr_q == `OFS_IDR)
               imr_q <= imr_q & ~hwdata[11:0]; // R23
         end
         if (wrThr) begin
            txHold_q <= hwdata;
            txHoldFull_q <= 1'b1;
            tx_ready_flag_q <= 1'b0;
         end
         if (swrst) begin
            rxEn_q <= 1'b0;
            txEn_q <= 1'b0;
            txHoldFull_q <= 1'b0;
            tx_ready_flag_q <= 1'b1;
            rx_ready_flag_q <= 1'b0;
            ovr_q <= 1'b0;
            tx_sync_flag_q <= 1'b0;
            rx_sync_flag_q <= 1'b0;
         end
      end
   end

   // read data mux
   always @* begin
      rdMux = 32'h0;
      if (haddr[7:0] == `OFS_CMR)
         rdMux = {20'h0, cmr_q};
      else if (haddr[7:0] == `OFS_RCMR)
         rdMux = rcmr_q;
      else if (haddr[7:0] == `OFS_RFMR)
         rdMux = rfmr_q;
      else if (haddr[7:0] == `OFS_TCMR)
         rdMux = tcmr_q;
      else if (haddr[7:0] == `OFS_TFMR)
         rdMux = tfmr_q;
      else if (haddr[7:0] == `OFS_RHR)
         rdMux = rxHold_q;
      else if (haddr[7:0] == `OFS_RSHR)
         rdMux = rxSyncHold_q;
      else if (haddr[7:0] == `OFS_TSHR)
         rdMux = {16'h0, txSyncHold_q};
      else if (haddr[7:0] == `OFS_SR)
         rdMux = {14'h0, rxEn_q, txEn_q, 4'h0, srFlags};
      else if (haddr[7:0] == `OFS_IMR)
         rdMux = {20'h0, imr_q};
   end

   // bus answer, status and pin registers
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= 1'b0;
         tx_empty_flag_q <= 1'b1;
         rxClockPinOut <= 1'b0;
         rxClockPinOe <= 1'b0;
         txClockPinOut <= 1'b0;
         txClockPinOe <= 1'b0;
         rxFrameSyncPinOe <= 1'b0;
         txFrameSyncPinOe <= 1'b0;
      end else begin
         hrdata <= rdNow ? rdMux : 32'h0;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         irq <= |(srFlags & imr_q); // R23
         tx_empty_flag_q <= ~txHoldFull_q & ~(txRun_q & (txBit_q != 5'h00)); // R6
         rxClockPinOut <= rxClkSel; // R2
         rxClockPinOe <= (rcmr_q[`CKO_RANGE] == 3'h1); // R3
         txClockPinOut <= divClk_q;
         txClockPinOe <= (cmr_q != 12'h000);
         rxFrameSyncPinOe <= (rxFsos != `FS_INPUT);
         txFrameSyncPinOe <= (txFsos != `FS_INPUT);
      end
   end

   // clock divider
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         divCnt_q <= 12'h000;
         divClk_q <= 1'b0;
         divPrev_q <= 1'b0;
         rxClkPrev_q <= 1'b0;
      end else begin
         divPrev_q <= divClk_q;
         rxClkPrev_q <= rxClkSel;
         if (cmr_q == 12'h000) begin
            divCnt_q <= 12'h000; // R24
            divClk_q <= 1'b0;
         end else if (divCnt_q == cmr_q - 12'h001) begin
            divCnt_q <= 12'h000;
            divClk_q <= ~divClk_q; // R24
         end else begin
            divCnt_q <= divCnt_q + 12'h001;
         end
      end
   end

   // transmitter frame engine on tx bit ticks
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         txRun_q <= 1'b0;
         txDly_q <= 8'h00;
         txSync_q <= 5'h00;
         txBit_q <= 5'h00;
         txWord_q <= 4'h0;
         txShift_q <= 32'h0;
         txSyncSh_q <= 16'h0000;
         txDataLine <= 1'b0;
         txFsPrev_q <= 1'b0;
         txPer_q <= 9'h000;
         txPulse_q <= 5'h00;
         txFrameSyncPinOut <= 1'b0;
      end else if (swrst || !txEn_q) begin
         txRun_q <= 1'b0;
         txDataLine <= tfmr_q[`DEFLOOP_BIT]; // R20
      end else if (txTick) begin
         txFsPrev_q <= txFsLevel;
         txPer_q <= txPerWrap ? 9'h000 : txPer_q + 9'h001; // R13
         txPulse_q <= txTrig ? {1'b0, tfmr_q[`FRAME_SYNC_LENGTH_RANGE]} + 5'h01 :
            (txPulse_q != 5'h00) ? txPulse_q - 5'h01 : 5'h00;
         txFrameSyncPinOut <= fsWave(txFsos, txTrig | (txPulse_q > 5'h01), txRun_q,
            txFrameSyncPinOut, txTrig); // R12
         txDataLine <= tfmr_q[`DEFLOOP_BIT]; // R20
         if (txStart) begin
            txRun_q <= 1'b1;
            txDly_q <= tcmr_q[`DLY_RANGE]; // R19
            txSync_q <= (tfmr_q[`SYNC_DATA_ENABLE_BIT] && txMode != `ST_CONT) ?
               {1'b0, tfmr_q[`FRAME_SYNC_LENGTH_RANGE]} + 5'h01 : 5'h00; // R16 R21
            txSyncSh_q <= txSyncHold_q;
            txBit_q <= 5'h00;
            txWord_q <= 4'h0;
         end else if (txRun_q && txDly_q != 8'h00) begin
            txDly_q <= txDly_q - 8'h01;
            if (txSync_q != 5'h00) begin
               txDataLine <= txSyncSh_q[0]; // R14
               txSyncSh_q <= txSyncSh_q >> 1;
               txSync_q <= txSync_q - 5'h01;
            end
         end else if (txRun_q) begin
            // data phase preempts any sync bits left
            if (txBit_q == 5'h00 && !txHoldFull_q) begin
               txRun_q <= 1'b0;
            end else begin
               if (txBit_q == 5'h00) begin
                  txDataLine <= tfmr_q[`MSB_FIRST_BIT] ? txHold_q[txLen] : txHold_q[0]; // R18
                  txShift_q <= tfmr_q[`MSB_FIRST_BIT] ? txHold_q << 1 : txHold_q >> 1; // R5
               end else begin
                  txDataLine <= tfmr_q[`MSB_FIRST_BIT] ? txShift_q[txLen] : txShift_q[0]; // R18
                  txShift_q <= tfmr_q[`MSB_FIRST_BIT] ? txShift_q << 1 : txShift_q >> 1;
               end
               if (txBit_q == txLen) begin
                  txBit_q <= 5'h00;
                  txWord_q <= txWord_q + 4'h1;
                  if (txWord_q == tfmr_q[`WORDS_PER_FRAME_RANGE])
                     txRun_q <= 1'b0; // R18
               end else begin
                  txBit_q <= txBit_q + 5'h01;
               end
            end
         end
      end
   end

   // receiver frame engine on rx bit ticks
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         rxRun_q <= 1'b0;
         rxDly_q <= 8'h00;
         rxSync_q <= 5'h00;
         rxBit_q <= 5'h00;
         rxWord_q <= 4'h0;
         rxShift_q <= 32'h0;
         rxHold_q <= 32'h0;
         rxSyncHold_q <= 32'h0;
         rxFsPrev_q <= 1'b0;
         rxPer_q <= 9'h000;
         rxPulse_q <= 5'h00;
         rxFrameSyncPinOut <= 1'b0;
      end else if (swrst || !rxEn_q) begin
         rxRun_q <= 1'b0;
      end else if (rxTick) begin
         rxFsPrev_q <= rxFsLevel;
         rxPer_q <= rxPerWrap ? 9'h000 : rxPer_q + 9'h001; // R13
         rxPulse_q <= rxTrig ? {1'b0, rfmr_q[`FRAME_SYNC_LENGTH_RANGE]} + 5'h01 :
            (rxPulse_q != 5'h00) ? rxPulse_q - 5'h01 : 5'h00;
         rxFrameSyncPinOut <= fsWave(rxFsos, rxTrig | (rxPulse_q > 5'h01), rxRun_q,
            rxFrameSyncPinOut, rxTrig); // R12
         if (rxStart) begin
            rxRun_q <= 1'b1;
            rxDly_q <= rcmr_q[`DLY_RANGE]; // R19
            rxSync_q <= (rxMode != `ST_CONT) ? {1'b0, rfmr_q[`FRAME_SYNC_LENGTH_RANGE]} + 5'h01 : 5'h00;
            rxShift_q <= 32'h0;
            rxBit_q <= 5'h00;
            rxWord_q <= 4'h0;
         end else if (rxRun_q && rxDly_q != 8'h00) begin
            rxDly_q <= rxDly_q - 8'h01;
            if (rxSync_q != 5'h00) begin
               rxShift_q <= {rxShift_q[30:0], rxData}; // R14 R15
               rxSync_q <= rxSync_q - 5'h01;
               if (rxSync_q == 5'h01)
                  rxSyncHold_q <= {rxShift_q[30:0], rxData}; // R15
            end
         end else if (rxRun_q) begin
            rxShift_q <= rfmr_q[`MSB_FIRST_BIT] ? {rxShift_q[30:0], rxData} :
               {rxData, rxShift_q[31:1]}; // R18
            if (rxDone) begin
               rxHold_q <= rfmr_q[`MSB_FIRST_BIT] ? rxMsbWord : rxLsbWord; // R7 R8
               rxBit_q <= 5'h00;
               rxWord_q <= rxWord_q + 4'h1;
               if (rxWord_q == rfmr_q[`WORDS_PER_FRAME_RANGE])
                  rxRun_q <= 1'b0; // R18
            end else begin
               rxBit_q <= rxBit_q + 5'h01;
            end
         end
      end
   end
endmodule // sync_serial_frame_engine

// ### rtl/sync_serial_defs.vh
`ifndef SYNC_SERIAL_DEFS_VH
`define SYNC_SERIAL_DEFS_VH

// register byte offsets
`define OFS_CR 8'h00
`define OFS_CMR 8'h04
`define OFS_RCMR 8'h10
`define OFS_RFMR 8'h14
`define OFS_TCMR 8'h18
`define OFS_TFMR 8'h1C
`define OFS_RHR 8'h20
`define OFS_THR 8'h24
`define OFS_RSHR 8'h30
`define OFS_TSHR 8'h34
`define OFS_SR 8'h40
`define OFS_IER 8'h44
`define OFS_IDR 8'h48
`define OFS_IMR 8'h4C

// control register bits
`define CR_RXEN 0
`define CR_RXDIS 1
`define CR_TXEN 8
`define CR_TXDIS 9
`define CR_SWRST 15

// clock mode fields
`define DIV_RANGE 11:0
`define CKS_RANGE 1:0
`define CKO_RANGE 4:2
`define CKI_BIT 5
`define START_RANGE 11:8
`define DLY_RANGE 23:16
`define PER_RANGE 31:24
`define CMR_MASK 32'h00000FFF
`define CLKMODE_MASK 32'hFFFF0F3F

// frame mode fields
`define WORD_LENGTH_RANGE 4:0
`define DEFLOOP_BIT 5
`define MSB_FIRST_BIT 7
`define WORDS_PER_FRAME_RANGE 11:8
`define FRAME_SYNC_LENGTH_RANGE 19:16
`define FRAME_SYNC_OUTPUT_SELECT_RANGE 22:20
`define SYNC_DATA_ENABLE_BIT 23
`define FRAME_SYNC_EDGE_SELECT_BIT 24
`define FRMMODE_MASK 32'h01FF0FBF

// status bits
`define SR_TX_READY_FLAG 0
`define SR_TX_EMPTY_FLAG 1
`define SR_RX_READY_FLAG 4
`define SR_OVRUN 5
`define SR_TX_SYNC_FLAG 10
`define SR_RX_SYNC_FLAG 11
`define SR_TXEN 16
`define SR_RXEN 17
`define IMR_MASK 12'hC33

// clock select codes
`define CKS_DIV 2'h0
`define CKS_TXCLK 2'h1
`define CKS_PIN 2'h2

// start codes
`define ST_CONT 4'h0
`define ST_OTHER 4'h1
`define ST_LOW 4'h2
`define ST_HIGH 4'h3
`define ST_FALL 4'h4
`define ST_RISE 4'h5
`define ST_CHANGE 4'h6
`define ST_EDGE 4'h7

// frame sync output codes
`define FS_INPUT 3'h0
`define FS_NEGPULSE 3'h1
`define FS_POSPULSE 3'h2
`define FS_LOWDATA 3'h3
`define FS_HIGHDATA 3'h4
`define FS_TOGGLE 3'h5

`endif

// ### rtl/pin_sync.v
`timescale 1ns/1ps
// two-stage synchroniser with level and edge outputs
module pin_sync (
   input wire clk,
   input wire rst,
   input wire pinIn,
   output wire level,
   output wire rise,
   output wire fall
);
   reg meta_q;
   reg stable_q;
   reg prev_q;

   // first stage feeds only the second
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= 1'b0;
         stable_q <= 1'b0;
         prev_q <= 1'b0;
      end else begin
         meta_q <= pinIn; // R28
         stable_q <= meta_q; // R28
         prev_q <= stable_q;
      end
   end

   // edges taken after the second stage only
   assign level = stable_q;
   assign rise = stable_q & ~prev_q;
   assign fall = ~stable_q & prev_q;
endmodule // pin_sync

// ### test/sync_serial_frame_engine_props.sv
`timescale 1ns/1ps
`include "sync_serial_defs.vh"
module sync_serial_frame_engine_props (
   input wire clk,
   input wire rst,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hresp,
   input wire rxClockPinOut,
   input wire rxClockPinOe,
   input wire txClockPinOut,
   input wire txClockPinOe,
   input wire txDataLine,
   input wire irq
);
   logic ph_q, wr_q, def_q, txOn_q;
   logic [7:0] a_q;
   logic [11:0] div_q, imr_q;
   logic [2:0] cko_q;
   logic [1:0] cks_q;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // shadow of the settings written over the bus
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         {ph_q, wr_q, def_q, txOn_q, a_q, div_q, imr_q, cko_q, cks_q} <= '0;
      end else begin
         ph_q <= hsel && htrans[1] && hready;
         wr_q <= hwrite;
         a_q <= haddr[7:0];
         if (ph_q && wr_q) begin
            case (a_q)
               `OFS_CR: txOn_q <= (txOn_q | hwdata[8]) & ~hwdata[9] & ~hwdata[15];
               `OFS_CMR: div_q <= hwdata[11:0];
               `OFS_RCMR: {cko_q, cks_q} <= hwdata[4:0];
               `OFS_TFMR: def_q <= hwdata[5];
               `OFS_IER: imr_q <= imr_q | hwdata[11:0];
               `OFS_IDR: imr_q <= imr_q & ~hwdata[11:0];
               default: ;
            endcase
         end
      end
   end
   a_resp_okay: assert property (!hresp) else $error("response not okay");
   a_rdata_idle: assert property (!(ph_q && !wr_q) |-> hrdata == 32'h0)
      else $error("read data outside data phase");
   a_unmapped_zero: assert property (ph_q && !wr_q && a_q > 8'h4C |-> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_txclk_enable: assert property ($stable(div_q) [*4] |-> txClockPinOe == (div_q != 12'h000))
      else $error("tx clock enable wrong");
   a_div_level: assert property (div_q == 12'h003 && $rose(txClockPinOut) |->
      txClockPinOut [*3] ##1 !txClockPinOut) else $error("divided level length wrong");
   a_rxclk_enable: assert property ($stable(cko_q) [*4] |-> rxClockPinOe == (cko_q == 3'h1))
      else $error("rx clock enable wrong");
   a_rxclk_follow: assert property (rxClockPinOe && cks_q != `CKS_PIN && $rose(txClockPinOut)
      |-> ##[0:2] $rose(rxClockPinOut)) else $error("rx clock out not following");
   a_irq_masked: assert property ((imr_q == 12'h000) [*3] |-> !irq)
      else $error("irq with empty mask");
   a_idle_data: assert property ((!txOn_q && $stable(def_q)) [*4] |-> txDataLine == def_q)
      else $error("idle data level wrong");
endmodule // sync_serial_frame_engine_props
bind sync_serial_frame_engine sync_serial_frame_engine_props props (.*);

// ### test/codec_model.sv
`timescale 1ns/1ps
module codec_model (
   input wire clk,
   input wire en,
   output logic clkOut = 1'b0,
   output logic dataOut = 1'b0,
   output logic syncOut
);
   logic [1:0] cnt_q = 2'h0;
   assign syncOut = 1'b0; // frame sync held idle low
   // bit clock only while enabled, each level three master clocks
   always @(posedge clk) begin
      cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
      if (en && cnt_q == 2'h2) clkOut <= ~clkOut;
      if (en && cnt_q == 2'h2 && !clkOut) dataOut <= ~dataOut; // new bit on each rising clock
   end
endmodule // codec_model

// ### test/testbench.sv
`timescale 1ns/1ps
`include "sync_serial_defs.vh"
module testbench;
   logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, en = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rv;
   int fail_count = 0, check_count = 0;
   wire [31:0] hrdata;
   wire hreadyout, hresp, rxClockPinOut, rxClockPinOe, rxFrameSyncPinOut, rxFrameSyncPinOe;
   wire txClockPinOut, txClockPinOe, txFrameSyncPinOut, txFrameSyncPinOe, txDataLine, irq;
   wire pinClk, rxDataIn, rxFrameSyncPinIn;
   wire [2:0] hsize = 3'h2;
   wire hready = hreadyout;
   wire txFrameSyncPinIn = rxFrameSyncPinIn;
   wire rxClockPinIn = rxClockPinOe ? rxClockPinOut : pinClk; // shared pin level
   sync_serial_frame_engine dut (.*);
   codec_model peer (.clk(clk), .en(en), .clkOut(pinClk), .dataOut(rxDataIn),
      .syncOut(rxFrameSyncPinIn));
   always #5 clk = ~clk;
   // one single word transfer, waits for ready in both phases
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic poll(input logic [31:0] m);
      int n;
      n = 0;
      do bus(1'b0, `OFS_SR, 32'h0, rv); while ((rv & m) !== m && ++n < 100);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic t_reset;
      bus(1'b0, `OFS_SR, 32'h0, rv);
      chk(rv, 32'h3);
      bus(1'b1, 8'h50, 32'h5, rv);
      bus(1'b0, 8'h50, 32'h0, rv);
      chk(rv, 32'h0);
   endtask
   task automatic t_irq;
      bus(1'b1, `OFS_IER, 32'h1, rv);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, `OFS_IMR, 32'h0, rv);
      chk(rv, 32'h1);
      bus(1'b1, `OFS_IDR, 32'h1, rv);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
   endtask
   task automatic t_loop;
      bus(1'b1, `OFS_CMR, 32'h3, rv);
      bus(1'b1, `OFS_TFMR, 32'hA7, rv);
      bus(1'b1, `OFS_RCMR, 32'h105, rv);
      bus(1'b1, `OFS_RFMR, 32'hA7, rv);
      bus(1'b1, `OFS_CR, 32'h101, rv);
      bus(1'b1, `OFS_THR, 32'hA5, rv);
      poll(32'h10);
      bus(1'b0, `OFS_RHR, 32'h0, rv);
      chk(rv, 32'hA5);
      bus(1'b1, `OFS_THR, 32'h3C, rv);
      poll(32'h1);
      bus(1'b1, `OFS_THR, 32'h5A, rv);
      repeat (300) @(posedge clk);
      bus(1'b1, `OFS_IER, 32'h20, rv);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      bus(1'b0, `OFS_SR, 32'h0, rv);
      chk(rv & 32'h33, 32'h33);
      repeat (3) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      bus(1'b0, `OFS_RHR, 32'h0, rv);
      chk(rv, 32'h5A);
   endtask
   task automatic t_pin;
      bus(1'b1, `OFS_CR, 32'h2, rv);
      bus(1'b1, `OFS_RCMR, 32'h2, rv);
      bus(1'b1, `OFS_RFMR, 32'h200007, rv);
      bus(1'b0, `OFS_RHR, 32'h0, rv);
      bus(1'b1, `OFS_CR, 32'h1, rv);
      repeat (100) @(posedge clk);
      bus(1'b0, `OFS_SR, 32'h0, rv);
      chk(rv & 32'h10, 32'h0);
      en <= 1'b1;
      poll(32'h10);
      en <= 1'b0;
      chk(rv & 32'h10, 32'h10);
      chk({31'h0, rxFrameSyncPinOe}, 32'h1);
      bus(1'b0, `OFS_RHR, 32'h0, rv);
      chk(rv, 32'hAA);
      bus(1'b1, `OFS_RCMR, 32'h25, rv);
      repeat (40) @(posedge clk);
   endtask
   // watchdog against a hung handshake
   initial begin
      #100000;
      fail_count++;
      test_done;
   end
   // reset, then the scenarios in turn
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_irq;
      t_loop;
      t_pin;
      test_done;
   end
endmodule // testbench
